// file: rtl/fdcm_top.sv
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module fdcm_top
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Controller state for the register dump
  input wire logic [3:0][7:0] pcn_drive,
  input wire logic [7:0] spec_srt_hut,
  input wire logic [7:0] spec_hlt_nd,
  input wire logic last_cmd_format,
  input wire logic [7:0] sectors_per_cylinder,
  input wire logic [7:0] final_sector_number,
  // Identifier search path
  input wire fdcm_pkg::fdcm_id_t id_field,
  input wire logic id_search_fail,
  output fdcm_pkg::fdcm_rid_t rid_req,
  // Head positioning and hand-off
  output fdcm_pkg::fdcm_seek_t seek_req,
  output logic foreign_valid,
  output logic [7:0] foreign_op,
  // Mode outputs
  output fdcm_pkg::fdcm_mode_t mode,
  output logic standby
);
  import fdcm_pkg::*;

  fdcm_state_t s;
  fdcm_state_t n;
  fdcm_cmd_t op_cmd;
  logic [1:0] op_npar;
  logic acc;
  logic [7:0] wbyte;
  logic [31:0] status_word;
  logic wr_idle;
  logic id_hit;

  fdcm_opdec u_opdec
  (
    .op_byte(wbyte),
    .op_cmd(op_cmd),
    .op_npar(op_npar)
  );

  // ****************************************
  // Bus slave
  // ****************************************
  // The slave never stalls, so every transfer completes in its first data phase.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel && htrans[1] && hready;
  assign wbyte = hwdata[7:0];
  assign wr_idle = s.wr_pend && (s.phase == FDCM_IDLE);
  assign id_hit = (s.phase == FDCM_EXEC) && id_field.valid && id_field.crc_ok;
  assign status_word = {23'h000000, s.mode.lock, s.rcnt, 1'b0, s.standby,
                        (s.phase == FDCM_RESULT),
                        (s.phase == FDCM_PARAM) || (s.phase == FDCM_EXEC)};

  // ****************************************
  // Command sequencer
  // ****************************************
  always_comb
  begin
    n = s;
    n.seek.valid = 1'b0;
    n.rid.start = 1'b0;
    n.fgn_valid = 1'b0;
    n.wr_pend = 1'b0;
    if (acc && !hwrite)
    begin
      n.hrdata = 32'h0000_0000;
      if (haddr == FDCM_OFS_DATA && s.phase == FDCM_RESULT)
      begin
        n.hrdata = {24'h000000, s.res[s.ridx]};
        n.ridx = s.ridx + 4'h1;
        n.rcnt = s.rcnt - 4'h1;
        if (s.rcnt == FDCM_NRES_ONE)
          n.phase = FDCM_IDLE;
      end
      else if (haddr == FDCM_OFS_STATUS)
        n.hrdata = status_word;
    end
    if (acc && hwrite)
      n.wr_pend = (haddr == FDCM_OFS_DATA);
    if (s.wr_pend)
    begin
      unique case (s.phase)
        FDCM_IDLE:
        begin
          n.standby = 1'b0;
          n.cmd = op_cmd;
          n.opb = wbyte;
          n.npar = op_npar;
          n.pidx = 2'h0;
          n.ridx = 4'h0;
          unique case (op_cmd)
            FDCM_CMD_INVALID:
            begin
              n.standby = 1'b1; // RQ1
              n.res[0] = FDCM_ST0_INVALID; // RQ2
              n.rcnt = FDCM_NRES_ONE; // RQ2
              n.phase = FDCM_RESULT;
            end
            FDCM_CMD_LOCK:
            begin
              n.mode.lock = wbyte[FDCM_LOCK_OP_BIT]; // RQ9
              n.res[0] = FDCM_ZERO_BYTE;
              n.res[0][FDCM_LOCK_RES_BIT] = wbyte[FDCM_LOCK_OP_BIT]; // RQ9
              n.rcnt = FDCM_NRES_ONE;
              n.phase = FDCM_RESULT;
            end
            FDCM_CMD_DUMPREG:
            begin
              n.res[0] = pcn_drive[0];
              n.res[1] = pcn_drive[1];
              n.res[2] = pcn_drive[2];
              n.res[3] = pcn_drive[3];
              n.res[4] = spec_srt_hut;
              n.res[5] = spec_hlt_nd;
              n.res[6] = last_cmd_format ? sectors_per_cylinder : final_sector_number; // RQ5 RQ6
              n.res[7] = {s.mode.lock, 1'b0, s.mode.perp};
              n.res[8] = {1'b0, s.mode.cfg};
              n.res[9] = s.mode.pretrk;
              n.rcnt = FDCM_NRES_DUMPREG;
              n.phase = FDCM_RESULT;
            end
            FDCM_CMD_FOREIGN:
            begin
              n.fgn_valid = 1'b1;
              n.fgn_op = wbyte;
            end
            FDCM_CMD_CONFIGURE, FDCM_CMD_RSEEK, FDCM_CMD_READID, FDCM_CMD_PERP:
              n.phase = FDCM_PARAM;
          endcase
        end
        FDCM_PARAM:
        begin
          n.par[s.pidx] = wbyte;
          n.pidx = s.pidx + 2'h1;
          if (n.pidx == s.npar)
          begin
            n.phase = FDCM_IDLE;
            unique case (s.cmd)
              FDCM_CMD_CONFIGURE:
              begin
                n.mode.cfg = n.par[1][6:0];
                n.mode.pretrk = n.par[2];
              end
              FDCM_CMD_RSEEK:
              begin
                // Drive bits only go to internal logic, never to drive select pins. RQ7
                n.seek.valid = 1'b1;
                n.seek.dir = s.opb[FDCM_DIR_BIT];
                n.seek.head_side_choice = n.par[0][2];
                n.seek.drive_pick_high = n.par[0][1];
                n.seek.drive_pick_low = n.par[0][0];
                n.seek.count = n.par[1];
              end
              FDCM_CMD_READID:
              begin
                n.rid.start = 1'b1; // RQ7
                n.rid.double_density_flag = s.opb[6];
                n.rid.head_side_choice = n.par[0][2];
                n.rid.drive_pick_high = n.par[0][1];
                n.rid.drive_pick_low = n.par[0][0];
                n.phase = FDCM_EXEC;
              end
              FDCM_CMD_PERP:
              begin
                // The drive bits 5:2 only change when the overwrite bit is set; bits 1:0 always change.
                if (n.par[0][FDCM_OW_BIT])
                  n.mode.perp[5:2] = n.par[0][5:2];
                n.mode.perp[1:0] = n.par[0][1:0];
              end
              FDCM_CMD_DUMPREG, FDCM_CMD_LOCK, FDCM_CMD_FOREIGN, FDCM_CMD_INVALID:
              begin
              end
            endcase
          end
        end
        FDCM_EXEC, FDCM_RESULT:
        begin
          // Bytes written while busy or during results are dropped.
        end
      endcase
    end
    // Fields with a bad check are skipped; the search goes on until one is clean or id_search_fail is raised.
    if (id_hit || (s.phase == FDCM_EXEC && id_search_fail))
    begin
      n.res[0] = {2'h0, 3'h0, s.rid.head_side_choice, s.rid.drive_pick_high,
                  s.rid.drive_pick_low}; // RQ4
      n.res[1] = FDCM_ZERO_BYTE;
      n.res[2] = FDCM_ZERO_BYTE;
      if (!id_hit)
      begin
        n.res[0][7:6] = FDCM_IC_ABNORMAL;
        n.res[1] = FDCM_ST1_NO_MARK;
      end
      n.res[3] = id_field.cyl; // RQ3
      n.res[4] = id_field.head; // RQ3
      n.res[5] = id_field.sector; // RQ3
      n.res[6] = id_field.size; // RQ3
      n.ridx = 4'h0;
      n.rcnt = FDCM_NRES_READID; // RQ4
      n.phase = FDCM_RESULT;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= n;
  end

  assign hrdata = s.hrdata;
  assign rid_req = s.rid;
  assign seek_req = s.seek;
  assign foreign_valid = s.fgn_valid;
  assign foreign_op = s.fgn_op;
  assign mode = s.mode;
  assign standby = s.standby;

  // ****************************************
  // Checks
  // ****************************************
  property p_invalid_result;
    @(posedge clk_sys) disable iff (!reset_n)
    wr_idle && op_cmd == FDCM_CMD_INVALID |=> s.phase == FDCM_RESULT &&
      s.rcnt == 4'h1 && s.res[0] == 8'h80;
  endproperty
  a_invalid_result: assert property (p_invalid_result) else $error("bad invalid result"); // RQ2

  property p_invalid_standby;
    @(posedge clk_sys) disable iff (!reset_n)
    wr_idle && op_cmd == FDCM_CMD_INVALID |=> standby ##1 (standby || $past(s.wr_pend));
  endproperty
  a_invalid_standby: assert property (p_invalid_standby) else $error("no standby"); // RQ1

  property p_lock_echo;
    @(posedge clk_sys) disable iff (!reset_n)
    wr_idle && op_cmd == FDCM_CMD_LOCK |=> s.res[0] == {3'h0, $past(hwdata[7]), 4'h0} &&
      mode.lock == $past(hwdata[7]);
  endproperty
  a_lock_echo: assert property (p_lock_echo) else $error("lock echo wrong"); // RQ9

  property p_rid_capture;
    @(posedge clk_sys) disable iff (!reset_n)
    id_hit |=> s.res[3] == $past(id_field.cyl) && s.res[5] == $past(id_field.sector) &&
      s.res[1] == 8'h00 && s.rcnt == 4'h7;
  endproperty
  a_rid_capture: assert property (p_rid_capture) else $error("id not captured"); // RQ3

  property p_rid_wait;
    @(posedge clk_sys) disable iff (!reset_n)
    s.phase == FDCM_EXEC && !(id_field.valid && id_field.crc_ok) && !id_search_fail
      |=> s.phase == FDCM_EXEC;
  endproperty
  a_rid_wait: assert property (p_rid_wait) else $error("read id left early"); // RQ3

  property p_rid_status;
    @(posedge clk_sys) disable iff (!reset_n)
    s.phase == FDCM_EXEC && id_search_fail && !id_hit |=> s.res[0][7:6] == 2'h1 &&
      s.res[1] == 8'h01 && s.ridx == 4'h0;
  endproperty
  a_rid_status: assert property (p_rid_status) else $error("bad id status"); // RQ4

  property p_dump_sc;
    @(posedge clk_sys) disable iff (!reset_n)
    wr_idle && op_cmd == FDCM_CMD_DUMPREG && last_cmd_format
      |=> s.res[6] == $past(sectors_per_cylinder) && s.rcnt == 4'hA;
  endproperty
  a_dump_sc: assert property (p_dump_sc) else $error("dump lacks sector count"); // RQ5

  property p_dump_eot;
    @(posedge clk_sys) disable iff (!reset_n)
    wr_idle && op_cmd == FDCM_CMD_DUMPREG && !last_cmd_format
      |=> s.res[6] == $past(final_sector_number);
  endproperty
  a_dump_eot: assert property (p_dump_eot) else $error("dump lacks final sector"); // RQ6

  property p_seek_drive;
    @(posedge clk_sys) disable iff (!reset_n)
    seek_req.valid |-> seek_req.drive_pick_low == s.par[0][0] &&
      seek_req.drive_pick_high == s.par[0][1] ##1 !seek_req.valid;
  endproperty
  a_seek_drive: assert property (p_seek_drive) else $error("seek drive bits wrong"); // RQ7
endmodule
`default_nettype wire

// file: pkg/fdcm_pkg.sv
// Behaviour
// RQ1 - An undefined first command byte is a no-operation that puts the block in standby.
// RQ2 - An undefined opcode returns one result byte, the invalid-command status pattern.
// RQ3 - Read identifier captures the first error-free identifier field on the cylinder.
// RQ4 - Read identifier results: three status bytes, then the captured identifier bytes.
// RQ5 - Register dump shared byte reports sectors per cylinder after a format command.
// RQ6 - Register dump shared byte reports final sector number after a read or write.
// RQ7 - Drive selection bits in parameters stay internal and never drive select outputs.
// RQ8 - Host keeps command drive bits consistent with the digital output register.
// RQ9 - Lock stores the opcode top bit and echoes it in one result byte bit.
`default_nettype none
package fdcm_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] FDCM_OFS_DATA = 32'h0000_0000;
  localparam logic [31:0] FDCM_OFS_STATUS = 32'h0000_0004;
  localparam int FDCM_STS_BUSY = 0;
  localparam int FDCM_STS_RESULT = 1;
  localparam int FDCM_STS_STANDBY = 2;
  localparam int FDCM_STS_CNT_LO = 4;
  localparam int FDCM_STS_LOCK = 8;
  // ****************************************
  // Opcodes and masks
  // ****************************************
  localparam logic [7:0] FDCM_OP_CONFIGURE = 8'h13;
  localparam logic [7:0] FDCM_OP_RSEEK = 8'h8F;
  localparam logic [7:0] FDCM_MSK_RSEEK = 8'hBF;
  localparam logic [7:0] FDCM_OP_DUMPREG = 8'h0E;
  localparam logic [7:0] FDCM_OP_READID = 8'h0A;
  localparam logic [7:0] FDCM_MSK_READID = 8'hBF;
  localparam logic [7:0] FDCM_OP_PERP = 8'h12;
  localparam logic [7:0] FDCM_OP_LOCK = 8'h14;
  localparam logic [7:0] FDCM_MSK_LOCK = 8'h7F;
  localparam logic [31:0] FDCM_FOREIGN_SET = 32'h2242_B3FC;
  localparam int FDCM_DIR_BIT = 6;
  localparam int FDCM_LOCK_OP_BIT = 7;
  localparam int FDCM_LOCK_RES_BIT = 4;
  localparam int FDCM_OW_BIT = 7;
  // ****************************************
  // Counts and status values
  // ****************************************
  localparam logic [1:0] FDCM_NPAR_CONFIGURE = 2'h3;
  localparam logic [1:0] FDCM_NPAR_RSEEK = 2'h2;
  localparam logic [1:0] FDCM_NPAR_ONE = 2'h1;
  localparam logic [1:0] FDCM_NPAR_NONE = 2'h0;
  localparam logic [3:0] FDCM_NRES_ONE = 4'h1;
  localparam logic [3:0] FDCM_NRES_READID = 4'h7;
  localparam logic [3:0] FDCM_NRES_DUMPREG = 4'hA;
  localparam logic [7:0] FDCM_ST0_INVALID = 8'h80;
  localparam logic [1:0] FDCM_IC_ABNORMAL = 2'h1;
  localparam logic [7:0] FDCM_ST1_NO_MARK = 8'h01;
  localparam logic [7:0] FDCM_ZERO_BYTE = 8'h00;

  typedef enum logic [2:0]
  {
    FDCM_CMD_CONFIGURE = 3'h0,
    FDCM_CMD_RSEEK = 3'h1,
    FDCM_CMD_DUMPREG = 3'h2,
    FDCM_CMD_READID = 3'h3,
    FDCM_CMD_PERP = 3'h4,
    FDCM_CMD_LOCK = 3'h5,
    FDCM_CMD_FOREIGN = 3'h6,
    FDCM_CMD_INVALID = 3'h7
  } fdcm_cmd_t;

  typedef enum logic [1:0]
  {
    FDCM_IDLE = 2'h0,
    FDCM_PARAM = 2'h1,
    FDCM_EXEC = 2'h2,
    FDCM_RESULT = 2'h3
  } fdcm_phase_t;

  typedef struct packed {
    logic valid;
    logic crc_ok;
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } fdcm_id_t;

  typedef struct packed {
    logic valid;
    logic dir;
    logic head_side_choice;
    logic drive_pick_high;
    logic drive_pick_low;
    logic [7:0] count;
  } fdcm_seek_t;

  typedef struct packed {
    logic start;
    logic double_density_flag;
    logic head_side_choice;
    logic drive_pick_high;
    logic drive_pick_low;
  } fdcm_rid_t;

  typedef struct packed {
    logic [6:0] cfg;
    logic [7:0] pretrk;
    logic [5:0] perp;
    logic lock;
  } fdcm_mode_t;

  typedef struct packed {
    fdcm_phase_t phase;
    fdcm_cmd_t cmd;
    logic [7:0] opb;
    logic [1:0] pidx;
    logic [1:0] npar;
    logic [2:0][7:0] par;
    logic [9:0][7:0] res;
    logic [3:0] ridx;
    logic [3:0] rcnt;
    logic wr_pend;
    logic [31:0] hrdata;
    logic standby;
    fdcm_mode_t mode;
    fdcm_seek_t seek;
    fdcm_rid_t rid;
    logic fgn_valid;
    logic [7:0] fgn_op;
  } fdcm_state_t;
endpackage
`default_nettype wire

// file: rtl/fdcm_opdec.sv
`timescale 1ns/100ps
`default_nettype none
module fdcm_opdec
(
  // Opcode in
  input wire logic [7:0] op_byte,
  // Decoded command
  output fdcm_pkg::fdcm_cmd_t op_cmd,
  output logic [1:0] op_npar
);
  import fdcm_pkg::*;

  always_comb
  begin
    op_cmd = FDCM_CMD_INVALID; // RQ1
    op_npar = FDCM_NPAR_NONE;
    if (op_byte == FDCM_OP_CONFIGURE)
    begin
      op_cmd = FDCM_CMD_CONFIGURE;
      op_npar = FDCM_NPAR_CONFIGURE;
    end
    else if ((op_byte & FDCM_MSK_RSEEK) == FDCM_OP_RSEEK)
    begin
      op_cmd = FDCM_CMD_RSEEK;
      op_npar = FDCM_NPAR_RSEEK;
    end
    else if (op_byte == FDCM_OP_DUMPREG)
      op_cmd = FDCM_CMD_DUMPREG;
    else if ((op_byte & FDCM_MSK_READID) == FDCM_OP_READID)
    begin
      op_cmd = FDCM_CMD_READID;
      op_npar = FDCM_NPAR_ONE;
    end
    else if (op_byte == FDCM_OP_PERP)
    begin
      op_cmd = FDCM_CMD_PERP;
      op_npar = FDCM_NPAR_ONE;
    end
    else if ((op_byte & FDCM_MSK_LOCK) == FDCM_OP_LOCK)
      op_cmd = FDCM_CMD_LOCK;
    // Opcodes served by the data transfer and positioning logic are handed on, not refused.
    else if (FDCM_FOREIGN_SET[op_byte[4:0]])
      op_cmd = FDCM_CMD_FOREIGN;
  end
endmodule
`default_nettype wire

// file: verif/fdcm_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fdcm_top_tb;
  import fdcm_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [3:0][7:0] pcn = '0;
  logic [7:0] srt = 8'h0;
  logic [7:0] hlt = 8'h0;
  logic fmt = 1'b0;
  logic [7:0] spc = 8'h0;
  logic [7:0] fsn = 8'h0;
  fdcm_id_t id_field = '0;
  logic id_fail = 1'b0;
  fdcm_rid_t rid_req;
  fdcm_seek_t seek_req;
  fdcm_seek_t seek_seen = '0;
  fdcm_rid_t rid_seen = '0;
  logic foreign_valid;
  logic [7:0] foreign_op;
  fdcm_mode_t mode;
  logic standby;
  int n_errors = 0;
  int n_tests = 0;
  int n_seek = 0;
  int n_fgn = 0;
  integer seed = 32'h6437561C;
  logic [31:0] rd;
  logic [31:0] g;
  logic [6:0] cfg_e;
  logic [7:0] pt_e;
  logic [5:0] perp_e = 6'h0;
  logic lk;
  logic [7:0] bad [4] = '{8'h00, 8'h18, 8'h1F, 8'hFF};

  fdcm_top dut
  (
    .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hsize(3'h2), .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pcn_drive(pcn),
    .spec_srt_hut(srt), .spec_hlt_nd(hlt), .last_cmd_format(fmt),
    .sectors_per_cylinder(spc), .final_sector_number(fsn), .id_field(id_field),
    .id_search_fail(id_fail), .rid_req(rid_req), .seek_req(seek_req),
    .foreign_valid(foreign_valid), .foreign_op(foreign_op), .mode(mode), .standby(standby)
  );

  always #50 clk_sys = ~clk_sys;

  // ****************************************
  // Pulse monitors
  // ****************************************
  // Pulses last one cycle, so they are latched here for later comparison.
  always @(posedge clk_sys)
  begin
    if (seek_req.valid === 1'b1)
    begin
      seek_seen <= seek_req;
      n_seek <= n_seek + 1;
    end
    if (rid_req.start === 1'b1)
      rid_seen <= rid_req;
    if (foreign_valid === 1'b1)
      n_fgn <= n_fgn + 1;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One single AHB transfer; entered just after a rising edge.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic cmd(input logic [7:0] b);
    bus(1'b1, FDCM_OFS_DATA, b);
  endtask

  task automatic res(input logic [7:0] e);
    bus(1'b0, FDCM_OFS_DATA, 8'h0);
    check(rd, {24'h0, e});
  endtask

  task automatic wait_res;
    int i;
    i = 0;
    rd = '0;
    while (rd[FDCM_STS_RESULT] !== 1'b1 && i < 40)
    begin
      bus(1'b0, FDCM_OFS_STATUS, 8'h0);
      i++;
    end
    check(32'(rd[FDCM_STS_RESULT]), 32'h1);
  endtask

  function automatic logic [7:0] dump_exp(input int i);
    case (i)
      0, 1, 2, 3: return pcn[i];
      4: return srt;
      5: return hlt;
      6: return fmt ? spc : fsn;
      7: return {lk, 1'b0, perp_e};
      8: return {1'b0, cfg_e};
      default: return pt_e;
    endcase
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    #2000000;
    n_errors++;
    end_of_test();
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    foreach (bad[k])
    begin
      cmd(bad[k]);
      wait_res();
      check(32'(standby), 32'h1);
      check(32'({hresp, hreadyout}), 32'h1);
      check(32'(rd[7:4]), 32'h1);
      res(FDCM_ST0_INVALID);
    end
    cmd(8'h0F);
    repeat (3) @(posedge clk_sys);
    check(32'(n_fgn), 32'h1);
    check(32'(standby), 32'h0);
    check(32'(foreign_op), 32'h0F);
    cfg_e = 7'($random(seed));
    pt_e = 8'($random(seed));
    cmd(FDCM_OP_CONFIGURE);
    cmd(8'h00);
    cmd({1'b0, cfg_e});
    cmd(pt_e);
    g = $random(seed);
    perp_e = g[5:0];
    cmd(FDCM_OP_PERP);
    cmd({2'b10, g[5:0]});
    g = $random(seed);
    perp_e[1:0] = g[1:0];
    cmd(FDCM_OP_PERP);
    cmd({2'b00, g[5:0]});
    for (int n = 0; n < 2; n++)
    begin
      lk = n[0] ^ 1'($random(seed));
      cmd({lk, 7'h14});
      wait_res();
      res({3'b000, lk, 4'h0});
      check(32'(mode.lock), 32'(lk));
    end
    for (int f = 0; f < 2; f++)
    begin
      pcn <= 32'($random(seed));
      srt <= 8'($random(seed));
      hlt <= 8'($random(seed));
      spc <= 8'($random(seed));
      fsn <= 8'($random(seed));
      fmt <= ~f[0];
      cmd(FDCM_OP_DUMPREG);
      wait_res();
      for (int i = 0; i < 10; i++)
        res(dump_exp(i));
    end
    for (int d = 0; d < 2; d++)
    begin
      g = $random(seed);
      cmd({1'b1, d[0], 6'h0F});
      cmd(8'h06);
      cmd(g[7:0]);
      repeat (3) @(posedge clk_sys);
      check(32'(n_seek), 32'(d + 1));
      check(32'(seek_seen), {19'h0, 1'b1, d[0], 3'b110, g[7:0]});
    end
    cmd(8'h4A);
    cmd(8'h06);
    repeat (3) @(posedge clk_sys);
    check(32'(rid_seen), 32'h1E);
    g = $random(seed);
    id_field <= {2'b10, ~g};
    @(posedge clk_sys);
    id_field <= {2'b11, g};
    @(posedge clk_sys);
    id_field <= {2'b11, ~g};
    @(posedge clk_sys);
    id_field <= '0;
    wait_res();
    res(8'h06);
    res(8'h00);
    res(8'h00);
    for (int i = 3; i >= 0; i--)
      res(g[8 * i +: 8]);
    cmd(FDCM_OP_READID);
    cmd(8'h02);
    repeat (3) @(posedge clk_sys);
    id_fail <= 1'b1;
    @(posedge clk_sys);
    id_fail <= 1'b0;
    wait_res();
    res(8'h42);
    res(FDCM_ST1_NO_MARK);
    res(8'h00);
    repeat (4) bus(1'b0, FDCM_OFS_DATA, 8'h0);
    bus(1'b0, FDCM_OFS_STATUS, 8'h0);
    check(32'(rd[FDCM_STS_RESULT]), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
